// ---- verilog/ubsbc_pkg.sv ----
// Package: register map, field layout, reset values and clock codes for the serial port control
package ubsbc_pkg;
  localparam logic [15:0] ADDR_STATUS  = 16'hFF55;
  localparam logic [15:0] ADDR_CLKSEL  = 16'hFF56;
  localparam logic [15:0] ADDR_DIVIDER = 16'hFF57;
  localparam logic [15:0] ADDR_CONTROL = 16'hFF58;

  localparam logic [7:0] RST_STATUS  = 8'h00;
  localparam logic [7:0] RST_CLKSEL  = 8'h00;
  localparam logic [7:0] RST_DIVIDER = 8'hFF;
  localparam logic [7:0] RST_CONTROL = 8'h16;

  localparam int BIT_SHIFT_BUSY = 0;
  localparam int BIT_BUF_FULL   = 1;
  localparam int BIT_INVERT     = 0;
  localparam int BIT_ORDER      = 1;
  localparam int BIT_TRIGGER    = 6;
  localparam int BIT_PROGRESS   = 7;
  localparam logic [3:0] CTRL_FIXED = 4'h5;

  localparam logic [3:0] CODE_MAX_DIV = 4'hA;
  localparam logic [3:0] CODE_TIMER   = 4'hB;
  localparam logic [7:0] DIV_MIN      = 8'h08;
  localparam logic [7:0] ZERO8        = 8'h00;

  typedef enum logic [1:0] {
    UBSBC_TX_IDLE  = 2'b00,
    UBSBC_TX_SHIFT = 2'b01
  } ubsbc_txst_t;
endpackage

// ---- verilog/ubsbc_baud_if.sv ----
// Interface: base clock tick and divider setting passed to the baud counter
`timescale 1ns/1ps
interface ubsbc_baud_if;
  logic       baseTick;
  logic [7:0] divK;
  logic       run;
  logic       bitTick;
  modport ctrl (output baseTick, output divK, output run, input bitTick);
  modport gen  (input baseTick, input divK, input run, output bitTick);
endinterface

// ---- verilog/ubsbc_baud_gen.sv ----
// Baud counter: divides the base clock tick by k, then halves it to the bit rate
`timescale 1ns/1ps
module ubsbc_baud_gen
  import ubsbc_pkg::*;
(
  input  wire logic mclk, // System clock
  input  wire logic rst,  // Synchronous reset
  ubsbc_baud_if.gen bi    // Base tick in, bit tick out
);
  logic [7:0] cnt_r, cnt_nxt;
  logic       half_r, half_nxt;
  logic       tick_r, tick_nxt;

  always_comb begin
    cnt_nxt  = cnt_r;
    half_nxt = half_r;
    tick_nxt = 1'b0;
    if (!bi.run) begin
      cnt_nxt  = ZERO8;
      half_nxt = 1'b0;
    end else if (bi.baseTick) begin
      if (cnt_r + 8'h01 >= bi.divK) begin
        cnt_nxt  = ZERO8;
        half_nxt = ~half_r;
        tick_nxt = half_r;
      end else begin
        cnt_nxt = cnt_r + 8'h01;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_r  <= ZERO8;
      half_r <= 1'b0;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      half_r <= half_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign bi.bitTick = tick_r;
endmodule

// ---- verilog/ubsbc_ctrl.sv ----
// Serial port control: status, base clock select, baud divider, break and line control
`timescale 1ns/1ps
// What this block does
// - Buffer-full flag sets on buffer write, clears on move to shifter or disable.
// - Shifter-busy flag sets on load, clears at end with no byte waiting.
// - Clock code 0..10 picks oscillator divided by power of two; 11 picks timer.
// - Baud counter divides base clock by k, k from 8 to 255; the divider also takes values below 8 as written, 0 dividing by 1.
// - Bit rate is baud counter output halved.
// - Rewriting same clock or divider value leaves communication undisturbed.
// - Writing trigger one starts break reception; trigger reads zero, self-clears.
// - Progress flag is one during break reception; clears on success or power enable low (receive enable low alone leaves it set).
// - On break error the progress flag stays one; software restarts.
// - Invert bit: zero drives line normally, one inverted.
// - Order bit: zero MSB first, one LSB first; change only when disabled.
// - Rewriting control with trigger one starts a fresh break reception.
// - Control bits 5..2 read 0101, bit 7 read-only, reset value 16H.
// - Power enable low stops the clock and resets flags and break bits.
// - Status register clears on reset, power or transmit enable low.
module ubsbc_ctrl
  import ubsbc_pkg::*;
(
  input  wire logic        mclk,             // System clock, 125 MHz
  input  wire logic        rst,              // Synchronous reset, active high
  input  wire logic [15:0] busAddr,          // CPU memory bus address
  input  wire logic        busWr,            // Write strobe
  input  wire logic        busRd,            // Read strobe
  input  wire logic [7:0]  busWdata,         // Write data
  output logic      [7:0]  busRdata,         // Read data, registered
  input  wire logic        oscClk,           // Oscillator level, sampled here
  input  wire logic        timerOut,         // Timer output level, sampled here
  input  wire logic        portPowerEnable,  // Power enable from mode register
  input  wire logic        transmitEnable,   // Transmit enable from mode register
  input  wire logic        receiveEnable,    // Receive enable from mode register
  input  wire logic        txBufferWrite,    // Pulse: software wrote the holding buffer
  input  wire logic        txShiftDone,      // Pulse: shifter finished a frame
  input  wire logic        breakRxOk,        // Pulse: break field received correctly
  input  wire logic        txSerialRaw,      // Serial data from the shifter
  output logic             serialOutLine,    // Serial output pin level
  output logic             txLoad,           // Pulse: move buffer into shifter
  output logic             bitTick,          // Pulse: one bit period elapsed
  output logic             bitOrderSelect,   // 0 MSB first, 1 LSB first
  output logic             breakRxStart,     // Pulse: begin break reception
  output logic             breakRxProgress   // Break reception in progress
);
  ubsbc_baud_if bi ();

  logic [3:0]  clkCode_r, clkCode_nxt;
  logic [7:0]  divK_r, divK_nxt;
  logic        bufFull_r, bufFull_nxt;
  logic        shBusy_r, shBusy_nxt;
  logic        order_r, order_nxt;
  logic        invert_r, invert_nxt;
  logic        prog_r, prog_nxt;
  logic        start_r, start_nxt;
  logic [10:0] pre_r, pre_nxt;
  logic        oscPrev_r, timerPrev_r;
  logic [7:0]  rdata_r, rdata_nxt;
  logic [7:0]  statusVal, controlVal;
  logic        txOn, oscEdge, timerEdge, wrCtrl;
  ubsbc_txst_t st_r, st_nxt;

  assign txOn      = portPowerEnable & transmitEnable;
  assign oscEdge   = oscClk & ~oscPrev_r;
  assign timerEdge = timerOut & ~timerPrev_r;
  assign wrCtrl    = busWr && (busAddr == ADDR_CONTROL);

  // Prescaler taps: tap n of the ripple count pulses at osc/2^n
  always_comb begin
    pre_nxt = pre_r;
    if (!portPowerEnable) begin
      pre_nxt = '0;
    end else if (oscEdge) begin
      pre_nxt = pre_r + 11'h001;
    end
    bi.baseTick = 1'b0;
    if (clkCode_r == CODE_TIMER) begin
      bi.baseTick = timerEdge;
    end else if (clkCode_r == 4'h0) begin
      bi.baseTick = oscEdge;
    end else if (clkCode_r <= CODE_MAX_DIV) begin
      // Pulse when the lower code bits roll over to zero
      bi.baseTick = oscEdge && ((pre_r & ((11'h001 << clkCode_r) - 11'h001))
                     == ((11'h001 << clkCode_r) - 11'h001));
    end
  end

  assign bi.divK = divK_r;
  assign bi.run  = portPowerEnable;
  assign bitTick = bi.bitTick;

  ubsbc_baud_gen uGen (
    .mclk (mclk),
    .rst  (rst),
    .bi   (bi)
  );

  // Registers, transmit occupancy and break control
  always_comb begin
    clkCode_nxt = clkCode_r;
    divK_nxt    = divK_r;
    order_nxt   = order_r;
    invert_nxt  = invert_r;
    bufFull_nxt = bufFull_r;
    shBusy_nxt  = shBusy_r;
    st_nxt      = st_r;
    prog_nxt    = prog_r;
    start_nxt   = 1'b0;
    txLoad      = 1'b0;
    // Same-value rewrites store the same value, so counters run on untouched
    if (busWr && busAddr == ADDR_CLKSEL) clkCode_nxt = busWdata[3:0];
    if (busWr && busAddr == ADDR_DIVIDER) divK_nxt = busWdata;
    if (wrCtrl) begin
      order_nxt  = busWdata[BIT_ORDER];
      invert_nxt = busWdata[BIT_INVERT];
    end
    unique case (st_r)
      UBSBC_TX_IDLE: begin
        if (bufFull_r) begin
          txLoad      = 1'b1;
          bufFull_nxt = 1'b0;
          shBusy_nxt  = 1'b1;
          st_nxt      = UBSBC_TX_SHIFT;
        end
      end
      UBSBC_TX_SHIFT: begin
        if (txShiftDone) begin
          if (bufFull_r) begin
            txLoad      = 1'b1;
            bufFull_nxt = 1'b0;
          end else begin
            shBusy_nxt = 1'b0;
            st_nxt     = UBSBC_TX_IDLE;
          end
        end
      end
    endcase
    if (txBufferWrite) bufFull_nxt = 1'b1;
    if (!txOn) begin
      // No move into a shifter that is being held in reset
      txLoad      = 1'b0;
      bufFull_nxt = 1'b0;
      shBusy_nxt  = 1'b0;
      st_nxt      = UBSBC_TX_IDLE;
    end
    // Success clears; an error simply never pulses breakRxOk, so the flag holds
    if (breakRxOk) prog_nxt = 1'b0;
    if (wrCtrl && busWdata[BIT_TRIGGER]) begin
      prog_nxt  = 1'b1;
      start_nxt = 1'b1;
    end
    if (!portPowerEnable && !receiveEnable) prog_nxt = 1'b0;
    if (!portPowerEnable) begin
      prog_nxt  = 1'b0;
      start_nxt = 1'b0;
    end
  end

  assign statusVal  = {6'b0, bufFull_r, shBusy_r};
  // Trigger always reads zero
  assign controlVal = {prog_r, 1'b0, CTRL_FIXED, order_r, invert_r};

  always_comb begin
    rdata_nxt = ZERO8;
    if (busRd) begin
      unique case (busAddr)
        ADDR_STATUS:  rdata_nxt = statusVal;
        ADDR_CLKSEL:  rdata_nxt = {4'h0, clkCode_r};
        ADDR_DIVIDER: rdata_nxt = divK_r;
        ADDR_CONTROL: rdata_nxt = controlVal;
        default:      rdata_nxt = ZERO8;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      clkCode_r   <= RST_CLKSEL[3:0];
      divK_r      <= RST_DIVIDER;
      order_r     <= RST_CONTROL[BIT_ORDER];
      invert_r    <= RST_CONTROL[BIT_INVERT];
      bufFull_r   <= RST_STATUS[BIT_BUF_FULL];
      shBusy_r    <= RST_STATUS[BIT_SHIFT_BUSY];
      st_r        <= UBSBC_TX_IDLE;
      prog_r      <= RST_CONTROL[BIT_PROGRESS];
      start_r     <= 1'b0;
      pre_r       <= '0;
      oscPrev_r   <= 1'b0;
      timerPrev_r <= 1'b0;
      rdata_r     <= ZERO8;
    end else begin
      clkCode_r   <= clkCode_nxt;
      divK_r      <= divK_nxt;
      order_r     <= order_nxt;
      invert_r    <= invert_nxt;
      bufFull_r   <= bufFull_nxt;
      shBusy_r    <= shBusy_nxt;
      st_r        <= st_nxt;
      prog_r      <= prog_nxt;
      start_r     <= start_nxt;
      pre_r       <= pre_nxt;
      oscPrev_r   <= oscClk;
      timerPrev_r <= timerOut;
      rdata_r     <= rdata_nxt;
    end
  end

  // Line idles high while powered down, as the port does
  assign serialOutLine   = portPowerEnable ? (txSerialRaw ^ invert_r) : 1'b1;
  assign busRdata        = rdata_r;
  assign bitOrderSelect  = order_r;
  assign breakRxStart    = start_r;
  assign breakRxProgress = prog_r;
endmodule

// ---- test/ubsbc_monitor.sv ----
// Checker: port-level assertions for the serial port control block
`timescale 1ns/1ps
module ubsbc_monitor
  import ubsbc_pkg::*;
(
  input wire logic        mclk,            // Clock
  input wire logic        rst,             // Reset
  input wire logic [15:0] busAddr,         // Address
  input wire logic        busWr,           // Write
  input wire logic        busRd,           // Read
  input wire logic [7:0]  busWdata,        // Write data
  input wire logic [7:0]  busRdata,        // Read data
  input wire logic        portPowerEnable, // Power
  input wire logic        transmitEnable,  // Transmit enable
  input wire logic        txLoad,          // Buffer to shifter move
  input wire logic        breakRxOk,       // Break done
  input wire logic        txSerialRaw,     // Raw line
  input wire logic        serialOutLine,   // Pin
  input wire logic        bitTick,         // Bit tick
  input wire logic        breakRxStart,    // Break start
  input wire logic        breakRxProgress  // Break busy
);
  logic invR;
  logic invNxt;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Shadow of the invert bit, so the pin can be judged without internal probes
  always_comb begin
    invNxt = invR;
    if (busWr && busAddr == ADDR_CONTROL) invNxt = busWdata[BIT_INVERT];
    if (rst) invNxt = RST_CONTROL[BIT_INVERT];
  end
  always_ff @(posedge mclk) invR <= invNxt;
  sequence trig_wr;
    busWr && busAddr == ADDR_CONTROL && busWdata[BIT_TRIGGER];
  endsequence
  sequence ctrl_rd;
    busRd && busAddr == ADDR_CONTROL;
  endsequence
  a_line_off: assert property (!portPowerEnable |-> serialOutLine)
    else $error("line not high while unpowered");
  a_line_invert: assert property (portPowerEnable |-> serialOutLine == (txSerialRaw ^ invR))
    else $error("line polarity wrong");
  a_trig_start: assert property (trig_wr ##0 portPowerEnable |=> breakRxStart && breakRxProgress)
    else $error("break not started");
  a_start_cause: assert property (breakRxStart |-> $past(busWr)
    && $past(busAddr) == ADDR_CONTROL && ($past(busWdata) & 8'h40) != 8'h00)
    else $error("break start without trigger");
  a_prog_clear: assert property ((!portPowerEnable || breakRxOk) && !(busWr
    && busAddr == ADDR_CONTROL && busWdata[BIT_TRIGGER]) |=> !breakRxProgress)
    else $error("progress not cleared");
  a_prog_hold: assert property (breakRxProgress && portPowerEnable && !breakRxOk |=> breakRxProgress)
    else $error("progress dropped early");
  a_ctrl_fixed: assert property (ctrl_rd |=> busRdata[5:2] == CTRL_FIXED && !busRdata[BIT_TRIGGER])
    else $error("control fixed bits wrong");
  a_idle_zero: assert property (!busRd |=> busRdata == ZERO8)
    else $error("read data not zero");
  a_bit_gap: assert property (bitTick |=> (!bitTick) [*8])
    else $error("bit ticks too close");
  a_load_enabled: assert property (txLoad |-> portPowerEnable && transmitEnable)
    else $error("buffer moved while transmitter disabled");
endmodule
bind ubsbc_ctrl ubsbc_monitor mon_u (.mclk(mclk), .rst(rst), .busAddr(busAddr), .busWr(busWr),
  .busRd(busRd), .busWdata(busWdata), .busRdata(busRdata), .portPowerEnable(portPowerEnable),
  .transmitEnable(transmitEnable), .txLoad(txLoad),
  .breakRxOk(breakRxOk), .txSerialRaw(txSerialRaw), .serialOutLine(serialOutLine),
  .bitTick(bitTick), .breakRxStart(breakRxStart), .breakRxProgress(breakRxProgress));

// ---- test/ubsbc_shifter_model.sv ----
// Partner: shifter and break detector standing behind the control block
`timescale 1ns/1ps
module ubsbc_shifter_model #(parameter int FRAME = 10) (
  input  wire logic mclk,        // Clock
  input  wire logic txLoad,      // Load from buffer
  input  wire logic bitTick,     // Bit period
  input  wire logic breakReq,    // Bench asks for a good break
  output logic      txShiftDone, // Frame finished
  output logic      txSerialRaw, // Shifter line
  output logic      breakRxOk    // Break received
);
  int cnt = 0;
  initial begin
    txShiftDone = 0;
    txSerialRaw = 1;
    breakRxOk = 0;
  end
  // Line toggles every bit so a stale level never passes for a match
  always @(posedge mclk) begin
    txShiftDone <= 0;
    breakRxOk <= breakReq;
    if (txLoad) cnt <= FRAME;
    else if (bitTick && cnt > 0) begin
      txSerialRaw <= ~txSerialRaw;
      cnt <= cnt - 1;
      if (cnt == 1) txShiftDone <= 1;
    end
  end
endmodule

// ---- test/uart_baud_status_and_break_control_tb.sv ----
// Testbench: register, bit rate, transmit flag and break checks
`timescale 1ns/1ps
module uart_baud_status_and_break_control_tb;
  import ubsbc_pkg::*;
  logic        mclk = 0, rst = 1, busWr = 0, busRd = 0, oscClk = 0, timerOut = 0;
  logic        pwr = 0, txe = 0, rxe = 0, txBufferWrite = 0, breakReq = 0;
  logic [15:0] busAddr = 16'h0000;
  logic [7:0]  busWdata = 8'h00;
  logic [7:0]  busRdata;
  logic [2:0]  tdiv = 3'h0;
  logic        txShiftDone, breakRxOk, txSerialRaw, serialOutLine, txLoad, bitTick;
  logic        bitOrderSelect, breakRxStart, breakRxProgress;
  int          n_errors = 0, checked = 0;
  initial begin
    forever #4 mclk = ~mclk;
  end
  // Crystal and a timer already started at 50 percent duty
  always @(negedge mclk) begin
    oscClk <= ~oscClk;
    tdiv <= tdiv + 3'h1;
    timerOut <= tdiv[2];
  end
  ubsbc_ctrl dut_u (.mclk(mclk), .rst(rst), .busAddr(busAddr), .busWr(busWr), .busRd(busRd),
    .busWdata(busWdata), .busRdata(busRdata), .oscClk(oscClk), .timerOut(timerOut),
    .portPowerEnable(pwr), .transmitEnable(txe), .receiveEnable(rxe),
    .txBufferWrite(txBufferWrite), .txShiftDone(txShiftDone), .breakRxOk(breakRxOk),
    .txSerialRaw(txSerialRaw), .serialOutLine(serialOutLine), .txLoad(txLoad),
    .bitTick(bitTick), .bitOrderSelect(bitOrderSelect), .breakRxStart(breakRxStart),
    .breakRxProgress(breakRxProgress));
  ubsbc_shifter_model #(.FRAME(10)) far_u (.mclk(mclk), .txLoad(txLoad), .bitTick(bitTick),
    .breakReq(breakReq), .txShiftDone(txShiftDone), .txSerialRaw(txSerialRaw),
    .breakRxOk(breakRxOk));
  task automatic wrap_up;
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [15:0] a, logic [7:0] d);
    @(negedge mclk);
    busAddr = a;
    busWdata = d;
    busWr = 1;
    @(negedge mclk);
    busWr = 0;
  endtask
  task automatic rd(logic [15:0] a, output logic [7:0] d);
    @(negedge mclk);
    busAddr = a;
    busRd = 1;
    @(negedge mclk);
    d = busRdata;
    busRd = 0;
  endtask
  task automatic rdchk(string w, logic [15:0] a, logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(w, e, d);
  endtask
  task automatic waitst(logic [7:0] e);
    logic [7:0] d;
    for (int i = 0; i < 400; i++) begin
      rd(ADDR_STATUS, d);
      if (d === e) return;
    end
    chk("status wait", e, d);
    wrap_up;
  endtask
  task automatic tick(output int n);
    for (n = 1; n < 300; n++) begin
      @(negedge mclk);
      if (bitTick === 1'b1) return;
    end
    chk("tick wait", 8'h01, 8'h00);
    wrap_up;
  endtask
  task automatic pulse_buf;
    @(negedge mclk);
    txBufferWrite = 1;
    @(negedge mclk);
    txBufferWrite = 0;
  endtask
  task automatic s_reset;
    rdchk("status", ADDR_STATUS, RST_STATUS);
    rdchk("clksel", ADDR_CLKSEL, RST_CLKSEL);
    rdchk("divider", ADDR_DIVIDER, RST_DIVIDER);
    rdchk("control", ADDR_CONTROL, RST_CONTROL);
    rdchk("unmapped", 16'hFF59, ZERO8);
    wr(ADDR_CONTROL, 8'hBD);
    wr(ADDR_STATUS, 8'hFF);
    wr(ADDR_CLKSEL, 8'hFF);
    rdchk("control ro", ADDR_CONTROL, 8'h15);
    rdchk("status ro", ADDR_STATUS, ZERO8);
    rdchk("clksel high", ADDR_CLKSEL, 8'h0F);
    chk("order", 8'h00, {7'h00, bitOrderSelect});
  endtask
  task automatic s_line;
    chk("line off", 8'h01, {7'h00, serialOutLine});
    pwr = 1;
    @(negedge mclk);
    chk("line inv", {7'h00, ~txSerialRaw}, {7'h00, serialOutLine});
    pwr = 0;
  endtask
  task automatic s_rate(logic [3:0] code, logic [7:0] k, logic [7:0] exp);
    int t;
    pwr = 0;
    rxe = 0;
    wr(ADDR_CLKSEL, {4'h0, code});
    wr(ADDR_DIVIDER, k);
    pwr = 1;
    tick(t);
    tick(t);
    chk("bit period", exp, t[7:0]);
    rxe = 1;
    wr(ADDR_DIVIDER, k);
    tick(t);
    tick(t);
    chk("period kept", exp, t[7:0]);
    rxe = 0;
  endtask
  task automatic s_tx;
    txe = 1;
    pulse_buf;
    waitst(8'h01);
    pulse_buf;
    waitst(8'h03);
    waitst(8'h01);
    waitst(8'h00);
    pulse_buf;
    txe = 0;
    rdchk("tx off", ADDR_STATUS, ZERO8);
  endtask
  task automatic s_break;
    rxe = 0;
    wr(ADDR_CONTROL, 8'h02);
    chk("order lsb", 8'h01, {7'h00, bitOrderSelect});
    chk("line normal", {7'h00, txSerialRaw}, {7'h00, serialOutLine});
    rxe = 1;
    wr(ADDR_CONTROL, 8'h42);
    rdchk("break busy", ADDR_CONTROL, 8'h96);
    breakReq = 1;
    @(negedge mclk);
    breakReq = 0;
    rdchk("break done", ADDR_CONTROL, 8'h16);
    wr(ADDR_CONTROL, 8'h42);
    repeat (50) @(negedge mclk);
    rdchk("break held", ADDR_CONTROL, 8'h96);
    rxe = 0;
    pwr = 0;
    rdchk("break off", ADDR_CONTROL, 8'h16);
  endtask
  initial begin
    repeat (20) @(negedge mclk);
    rst = 0;
    s_reset;
    s_line;
    s_rate(4'h0, 8'h08, 8'h20);
    s_rate(4'h1, 8'h08, 8'h40);
    s_rate(4'h0, 8'h09, 8'h24);
    s_rate(CODE_TIMER, 8'h08, 8'h80);
    s_rate(4'h0, 8'h08, 8'h20);
    s_tx;
    s_break;
    wrap_up;
  end
endmodule
